// ### hw/podl_pse_consts.svh
`ifndef PODL_PSE_CONSTS_SVH
`define PODL_PSE_CONSTS_SVH

// Timebase: one tick per microsecond
`define CLK_FREQ_MHZ 40
`define TICK_US 1
`define TICK_CYCLES (`CLK_FREQ_MHZ * `TICK_US)

// Times in microseconds, tick counts derived from them
`define T_PREBIAS_HOLD_US 100
`define T_SIG_HOLD_US 1000
`define T_DET_MAX_US 3110
`define T_RST_PULSE_US 10000
`define T_PRES_START_MIN_US 500
`define T_PRES_START_MAX_US 1500
`define T_PRES_LOW_MIN_US 2500
`define T_PRES_LOW_MAX_US 7500
`define T_SLOT_US 3000
`define T_WR1_LOW_US 500
`define T_WR0_LOW_US 2000
`define T_RD_INIT_US 100
`define T_RD_SAMPLE_US 1000
`define N_PREBIAS_HOLD (`T_PREBIAS_HOLD_US / `TICK_US)
`define N_SIG_HOLD (`T_SIG_HOLD_US / `TICK_US)
`define N_DET_MAX (`T_DET_MAX_US / `TICK_US)
`define N_RST_PULSE (`T_RST_PULSE_US / `TICK_US)
`define N_PRES_START_MIN (`T_PRES_START_MIN_US / `TICK_US)
`define N_PRES_START_MAX (`T_PRES_START_MAX_US / `TICK_US)
`define N_PRES_LOW_MIN (`T_PRES_LOW_MIN_US / `TICK_US)
`define N_PRES_LOW_MAX (`T_PRES_LOW_MAX_US / `TICK_US)
`define N_SLOT (`T_SLOT_US / `TICK_US)
`define N_WR1_LOW (`T_WR1_LOW_US / `TICK_US)
`define N_WR0_LOW (`T_WR0_LOW_US / `TICK_US)
`define N_RD_INIT (`T_RD_INIT_US / `TICK_US)
`define N_RD_SAMPLE (`T_RD_SAMPLE_US / `TICK_US)

// Classification commands and transfer length
`define CMD_BROADCAST 8'hcc
`define CMD_READ_SCRATCH 8'haa
`define XFER_BITS 6'd40
`define TX_BITS 6'd16
`define CRC_FIRST_BIT 6'd16
`define CRC_LAST_BIT 6'd31
`define CRC8_POLY_REV 8'h8c
`define NUM_CLASSES 4'd10

// Register offsets
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_IRQ_STATUS 8'h08
`define ADDR_IRQ_MASK 8'h0c

// Control fields
`define CTRL_ENABLE 0
`define CTRL_CLASS_EN 1
`define CTRL_MASK_LSB 2
`define CTRL_MASK_MSB 11
`define CTRL_RESET 12'hffc

// Interrupt bits
`define IRQ_POWERED 0
`define IRQ_NO_PRESENCE 1
`define IRQ_CRC_ERR 2
`define IRQ_CLASS_ERR 3
`define IRQ_DET_TIMEOUT 4
`define IRQ_WIDTH 5

`endif

// ### hw/podl_pse_pkg.sv
package podl_pse_pkg;

   typedef enum logic [3:0] {
      ST_DISABLED = 4'h0,
      ST_PREBIAS = 4'h1,
      ST_DETECT = 4'h2,
      ST_RST_PULSE = 4'h3,
      ST_PRES_WAIT = 4'h4,
      ST_PRES_LOW = 4'h5,
      ST_XFER = 4'h6,
      ST_CHECK = 4'h7,
      ST_POWER_ON = 4'h8
   } seq_state_type;

   typedef enum logic [1:0] {
      SL_IDLE = 2'h0,
      SL_LOW = 2'h1,
      SL_HIGH = 2'h2
   } slot_state_type;

endpackage

// ### hw/hold_filter.sv
// ==========================================================
// Continuous-hold qualifier
module hold_filter #(
   parameter logic [15:0] HOLD = 16'h0001
) (
   input wire logic clk, // System clock
   input wire logic rst_n, // Async reset, active low
   input wire logic tick, // One-microsecond enable
   input wire logic clear, // Restart qualification
   input wire logic level, // Raw indication
   output logic ok // Held long enough
);
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic ok_next;

   assign ok_next = (cnt_reg >= HOLD);
   assign cnt_next = (clear || !level) ? 16'h0000 :
                     (tick && !ok_next) ? cnt_reg + 16'h0001 : cnt_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 16'h0000;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign ok = ok_next && level && !clear;
endmodule

// ### hw/sccp_slot.sv
`include "podl_pse_consts.svh"

// ==========================================================
// One classification bit slot on the shared line
module sccp_slot (
   input wire logic clk, // System clock
   input wire logic rst_n, // Async reset, active low
   input wire logic tick, // One-microsecond enable
   input wire logic go, // Start a slot
   input wire logic is_read, // Slot reads a bit from the far end
   input wire logic wr_bit, // Bit to send
   input wire logic line_in, // Line level
   output logic idle, // Ready for a slot
   output logic done, // Slot finished, one cycle
   output logic rd_bit, // Sampled bit
   output logic line_oe // Pull line low
);
   podl_pse_pkg::slot_state_type state_reg;
   podl_pse_pkg::slot_state_type state_next;
   logic [15:0] cnt_reg;
   logic rd_reg;
   logic wr_reg;
   logic rd_mode_reg;
   logic [15:0] low_len;
   logic low_end;
   logic slot_end;
   logic sample_now;

   assign low_len = rd_mode_reg ? 16'(`N_RD_INIT) : (wr_reg ? 16'(`N_WR1_LOW) : 16'(`N_WR0_LOW));
   assign low_end = tick && (cnt_reg + 16'h0001 >= low_len);
   assign slot_end = tick && (cnt_reg + 16'h0001 >= 16'(`N_SLOT));
   assign sample_now = tick && rd_mode_reg && (cnt_reg == 16'(`N_RD_SAMPLE));

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         podl_pse_pkg::SL_IDLE: if (go) state_next = podl_pse_pkg::SL_LOW;
         podl_pse_pkg::SL_LOW: if (low_end) state_next = podl_pse_pkg::SL_HIGH;
         podl_pse_pkg::SL_HIGH: if (slot_end) state_next = podl_pse_pkg::SL_IDLE;
         default: state_next = podl_pse_pkg::SL_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= podl_pse_pkg::SL_IDLE;
         cnt_reg <= 16'h0000;
         rd_reg <= 1'b0;
         wr_reg <= 1'b0;
         rd_mode_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (state_reg == podl_pse_pkg::SL_IDLE) begin
            cnt_reg <= 16'h0000;
            wr_reg <= wr_bit;
            rd_mode_reg <= is_read;
         end else if (tick) begin
            cnt_reg <= cnt_reg + 16'h0001;
         end
         if (sample_now) begin
            rd_reg <= line_in;
         end
      end
   end

   assign idle = (state_reg == podl_pse_pkg::SL_IDLE);
   assign done = (state_reg == podl_pse_pkg::SL_HIGH) && slot_end;
   assign rd_bit = rd_reg;
   assign line_oe = (state_reg == podl_pse_pkg::SL_LOW);
endmodule

// ### hw/podl_pse_port_power_sequencer.sv
// Design decisions made here: the plain strobed port and the placing of the registers.
`include "podl_pse_consts.svh"

module podl_pse_port_power_sequencer #(
   parameter logic [15:0] TICK_DIV = 16'(`TICK_CYCLES)
) (
   input wire logic CLK_SYS, // 40 MHz clock
   input wire logic RST_N, // Async reset, active low
   input wire logic [7:0] ADDR, // Register byte address
   input wire logic [31:0] WDATA, // Write data
   input wire logic WR, // Write strobe
   input wire logic RD, // Read strobe
   output logic [31:0] RDATA, // Read data, cycle after RD
   output logic IRQ, // Level interrupt
   input wire logic PREBIAS_CURRENT_OK, // Prebias current in window
   input wire logic SIGNATURE_WINDOW_OK, // Signature comparator
   output logic PREBIAS_EN, // Prebias source on
   output logic DET_SRC_EN, // Detection current source on
   output logic PORT_ON, // Power switch on
   input wire logic LINE_I, // Line level
   output logic LINE_O, // Line drive value
   output logic LINE_OE // Line pulled low
);
   // ==========================================================
   // Microsecond tick
   logic [15:0] div_reg;
   logic tick;

   assign tick = (div_reg == TICK_DIV - 16'h0001);

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         div_reg <= 16'h0000;
      end else begin
         div_reg <= tick ? 16'h0000 : div_reg + 16'h0001;
      end
   end

   // ==========================================================
   // Registers
   logic [11:0] ctrl_reg;
   logic [`IRQ_WIDTH-1:0] irq_stat_reg;
   logic [`IRQ_WIDTH-1:0] irq_mask_reg;
   logic [31:0] rdata_reg;
   logic [`IRQ_WIDTH-1:0] irq_event;
   logic hw_disable;
   logic wr_ctrl;
   logic wr_stat;
   logic wr_mask;
   logic [31:0] status_word;
   logic [31:0] rd_mux;
   logic port_enable;
   logic class_enable;
   logic [9:0] class_mask;

   assign wr_ctrl = WR && (ADDR == `ADDR_CTRL);
   assign wr_stat = WR && (ADDR == `ADDR_IRQ_STATUS);
   assign wr_mask = WR && (ADDR == `ADDR_IRQ_MASK);
   assign port_enable = ctrl_reg[`CTRL_ENABLE];
   assign class_enable = ctrl_reg[`CTRL_CLASS_EN];
   assign class_mask = ctrl_reg[`CTRL_MASK_MSB:`CTRL_MASK_LSB];

   // ==========================================================
   // Sequencer state
   podl_pse_pkg::seq_state_type state_reg;
   podl_pse_pkg::seq_state_type state_next;
   logic [15:0] timer_reg;
   logic [5:0] bit_reg;
   logic [23:0] rx_reg;
   logic [7:0] crc_reg;
   logic prebias_ok;
   logic sig_ok;
   logic slot_idle;
   logic slot_done;
   logic slot_bit;
   logic slot_oe;
   logic slot_go;
   logic slot_read;
   logic tx_bit;
   logic last_bit;
   logic crc_ok;
   logic class_ok;
   logic [3:0] rx_class;
   logic det_timeout;
   logic in_prebias;
   logic in_detect;
   logic [15:0] tx_word;

   function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic din);
      logic fb;
      fb = crc[0] ^ din;
      crc8_step = {1'b0, crc[7:1]} ^ (fb ? `CRC8_POLY_REV : 8'h00);
   endfunction

   assign in_prebias = (state_reg == podl_pse_pkg::ST_PREBIAS);
   assign in_detect = (state_reg == podl_pse_pkg::ST_DETECT);
   assign tx_word = {`CMD_READ_SCRATCH, `CMD_BROADCAST};
   assign slot_read = (bit_reg >= `TX_BITS);
   assign tx_bit = tx_word[bit_reg[3:0]];
   assign slot_go = (state_reg == podl_pse_pkg::ST_XFER) && slot_idle;
   assign last_bit = slot_done && (bit_reg == `XFER_BITS - 6'd1);
   assign rx_class = rx_reg[3:0];
   assign crc_ok = (crc_reg == rx_reg[23:16]);
   assign class_ok = (rx_class < `NUM_CLASSES) && class_mask[rx_class];
   assign det_timeout = in_detect && !sig_ok && tick && (timer_reg + 16'h0001 >= 16'(`N_DET_MAX));

   hold_filter #(
      .HOLD(16'(`N_PREBIAS_HOLD))
   ) u_prebias_filter (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .tick(tick),
      .clear(!in_prebias),
      .level(PREBIAS_CURRENT_OK),
      .ok(prebias_ok)
   );

   hold_filter #(
      .HOLD(16'(`N_SIG_HOLD))
   ) u_signature_filter (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .tick(tick),
      .clear(!in_detect),
      .level(SIGNATURE_WINDOW_OK),
      .ok(sig_ok)
   );

   sccp_slot u_slot (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .tick(tick),
      .go(slot_go),
      .is_read(slot_read),
      .wr_bit(tx_bit),
      .line_in(LINE_I),
      .idle(slot_idle),
      .done(slot_done),
      .rd_bit(slot_bit),
      .line_oe(slot_oe)
   );

   // ==========================================================
   // Next state and events
   always_comb begin
      state_next = state_reg;
      irq_event = '0;
      hw_disable = 1'b0;
      unique case (state_reg)
         podl_pse_pkg::ST_DISABLED: begin
            if (port_enable) state_next = podl_pse_pkg::ST_PREBIAS;
         end
         podl_pse_pkg::ST_PREBIAS: begin
            if (prebias_ok) state_next = podl_pse_pkg::ST_DETECT;
         end
         podl_pse_pkg::ST_DETECT: begin
            if (sig_ok) begin
               state_next = class_enable ? podl_pse_pkg::ST_RST_PULSE : podl_pse_pkg::ST_POWER_ON;
            end else if (det_timeout) begin
               state_next = podl_pse_pkg::ST_PREBIAS;
               irq_event[`IRQ_DET_TIMEOUT] = 1'b1;
            end
         end
         podl_pse_pkg::ST_RST_PULSE: begin
            if (tick && timer_reg + 16'h0001 >= 16'(`N_RST_PULSE)) state_next = podl_pse_pkg::ST_PRES_WAIT;
         end
         podl_pse_pkg::ST_PRES_WAIT: begin
            if (!LINE_I && timer_reg >= 16'(`N_PRES_START_MIN)) begin
               state_next = podl_pse_pkg::ST_PRES_LOW;
            end else if (!LINE_I || timer_reg > 16'(`N_PRES_START_MAX)) begin
               state_next = podl_pse_pkg::ST_DISABLED;
               irq_event[`IRQ_NO_PRESENCE] = 1'b1;
               hw_disable = 1'b1;
            end
         end
         podl_pse_pkg::ST_PRES_LOW: begin
            if (LINE_I && timer_reg >= 16'(`N_PRES_LOW_MIN)) begin
               state_next = podl_pse_pkg::ST_XFER;
            end else if (LINE_I || timer_reg > 16'(`N_PRES_LOW_MAX)) begin
               state_next = podl_pse_pkg::ST_DISABLED;
               irq_event[`IRQ_NO_PRESENCE] = 1'b1;
               hw_disable = 1'b1;
            end
         end
         podl_pse_pkg::ST_XFER: begin
            if (last_bit) state_next = podl_pse_pkg::ST_CHECK;
         end
         podl_pse_pkg::ST_CHECK: begin
            if (crc_ok && class_ok) begin
               state_next = podl_pse_pkg::ST_POWER_ON;
            end else begin
               state_next = podl_pse_pkg::ST_DISABLED;
               irq_event[`IRQ_CRC_ERR] = !crc_ok;
               irq_event[`IRQ_CLASS_ERR] = crc_ok;
               hw_disable = 1'b1;
            end
         end
         podl_pse_pkg::ST_POWER_ON: begin
            if (!port_enable) state_next = podl_pse_pkg::ST_DISABLED;
         end
         default: state_next = podl_pse_pkg::ST_DISABLED;
      endcase
      if (!port_enable) begin
         state_next = podl_pse_pkg::ST_DISABLED;
      end
      // Powered flag only for a transition that really happens
      if (state_next == podl_pse_pkg::ST_POWER_ON && state_reg != podl_pse_pkg::ST_POWER_ON) begin
         irq_event[`IRQ_POWERED] = 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         state_reg <= podl_pse_pkg::ST_DISABLED;
         timer_reg <= 16'h0000;
      end else begin
         state_reg <= state_next;
         if (state_next != state_reg) begin
            timer_reg <= 16'h0000;
         end else if (tick && timer_reg != 16'hffff) begin
            timer_reg <= timer_reg + 16'h0001;
         end
      end
   end

   // ==========================================================
   // Bit counter, receive shifter and checksum
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         bit_reg <= 6'd0;
         rx_reg <= 24'h000000;
         crc_reg <= 8'h00;
      end else if (state_reg != podl_pse_pkg::ST_XFER && state_reg != podl_pse_pkg::ST_CHECK) begin
         bit_reg <= 6'd0;
         crc_reg <= 8'h00;
      end else if (slot_done) begin
         bit_reg <= bit_reg + 6'd1;
         if (slot_read) begin
            rx_reg <= {slot_bit, rx_reg[23:1]};
         end
         if (bit_reg >= `CRC_FIRST_BIT && bit_reg <= `CRC_LAST_BIT) begin
            crc_reg <= crc8_step(crc_reg, slot_bit);
         end
      end
   end

   // ==========================================================
   // Register file and interrupt
   assign status_word = {8'h00, rx_reg[15:0], 3'h0, PORT_ON, state_reg};
   assign rd_mux = (ADDR == `ADDR_CTRL) ? {20'h00000, ctrl_reg} :
                   (ADDR == `ADDR_STATUS) ? status_word :
                   (ADDR == `ADDR_IRQ_STATUS) ? {27'h0000000, irq_stat_reg} :
                   (ADDR == `ADDR_IRQ_MASK) ? {27'h0000000, irq_mask_reg} : 32'h00000000;

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_reg <= `CTRL_RESET;
         irq_stat_reg <= '0;
         irq_mask_reg <= '0;
         rdata_reg <= 32'h00000000;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= WDATA[11:0];
         end else if (hw_disable) begin
            ctrl_reg[`CTRL_ENABLE] <= 1'b0;
         end
         irq_stat_reg <= (irq_stat_reg & ~(wr_stat ? WDATA[`IRQ_WIDTH-1:0] : '0)) | irq_event;
         if (wr_mask) begin
            irq_mask_reg <= WDATA[`IRQ_WIDTH-1:0];
         end
         rdata_reg <= RD ? rd_mux : 32'h00000000;
      end
   end

   assign RDATA = rdata_reg;
   assign IRQ = |(irq_stat_reg & irq_mask_reg);

   // ==========================================================
   // Pin drive
   assign PREBIAS_EN = in_prebias;
   assign DET_SRC_EN = (state_reg >= podl_pse_pkg::ST_DETECT) && (state_reg <= podl_pse_pkg::ST_CHECK);
   assign PORT_ON = (state_reg == podl_pse_pkg::ST_POWER_ON);
   assign LINE_O = 1'b0;
   assign LINE_OE = (state_reg == podl_pse_pkg::ST_RST_PULSE) || slot_oe;
endmodule

// ### sim/podl_pse_chk.sv
`include "podl_pse_consts.svh"

// ==========================================
// Port checker for the sequencer
module podl_pse_chk #(
   parameter logic [15:0] TICK_DIV = 16'h0028
) (
   input wire logic CLK_SYS, // Clock
   input wire logic RST_N, // Reset
   input wire logic [7:0] ADDR, // Address
   input wire logic [31:0] WDATA, // Write data
   input wire logic WR, // Write
   input wire logic RD, // Read
   input wire logic [31:0] RDATA, // Read data
   input wire logic IRQ, // Interrupt
   input wire logic PREBIAS_CURRENT_OK, // Prebias in window
   input wire logic SIGNATURE_WINDOW_OK, // Signature in window
   input wire logic PREBIAS_EN, // Prebias on
   input wire logic DET_SRC_EN, // Detection source on
   input wire logic PORT_ON, // Power on
   input wire logic LINE_I, // Line level
   input wire logic LINE_O, // Line value
   input wire logic LINE_OE // Line pulled low
);
   logic [31:0] tk;
   logic [31:0] ok_cnt;
   logic [31:0] sig_cnt;
   logic [31:0] det_cnt;
   logic [31:0] oe_cnt;
   logic [31:0] gap_cnt;
   logic xfer_seen;
   assign tk = 32'(TICK_DIV);
   // Run lengths of inputs and outputs, and whether classification began
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         ok_cnt <= 32'h0;
         sig_cnt <= 32'h0;
         det_cnt <= 32'h0;
         oe_cnt <= 32'h0;
         gap_cnt <= 32'h0;
         xfer_seen <= 1'b0;
      end else begin
         ok_cnt <= PREBIAS_CURRENT_OK ? ok_cnt + 1 : 32'h0;
         sig_cnt <= SIGNATURE_WINDOW_OK ? sig_cnt + 1 : 32'h0;
         det_cnt <= (DET_SRC_EN && !LINE_OE && !xfer_seen) ? det_cnt + 1 : 32'h0;
         oe_cnt <= LINE_OE ? oe_cnt + 1 : 32'h0;
         gap_cnt <= (LINE_OE && oe_cnt == 32'h0) ? 32'h1 : gap_cnt + 1;
         xfer_seen <= DET_SRC_EN && (xfer_seen || LINE_OE);
      end
   end
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   // ==========================================
   // Assertions
   dis_all_off_a:
   assert property ((WR && ADDR == `ADDR_CTRL && !WDATA[`CTRL_ENABLE]) ##1 !WR
      |=> !PREBIAS_EN && !DET_SRC_EN && !PORT_ON && !LINE_OE) else $error("outputs on after disable");
   det_after_prebias_a:
   assert property ($rose(DET_SRC_EN) |-> $past(PREBIAS_EN) && $past(PREBIAS_CURRENT_OK))
      else $error("detection source without prebias");
   prebias_hold_a:
   assert property ($rose(DET_SRC_EN) |-> ok_cnt >= 99 * tk) else $error("prebias hold too short");
   sig_hold_a:
   assert property (($rose(PORT_ON) || $rose(LINE_OE)) && !xfer_seen |-> sig_cnt >= 999 * tk)
      else $error("signature hold too short");
   det_time_a:
   assert property (det_cnt <= 3112 * tk) else $error("detection too long");
   det_exit_a:
   assert property (DET_SRC_EN && !LINE_OE && !xfer_seen |-> det_cnt < 1003 * tk || sig_cnt < 1003 * tk)
      else $error("valid detection not acted on");
   reset_pulse_a:
   assert property ($fell(LINE_OE) && oe_cnt > 5000 * tk |-> oe_cnt >= 9999 * tk && oe_cnt <= 10001 * tk)
      else $error("reset pulse length wrong");
   slot_len_a:
   assert property ($rose(LINE_OE) && xfer_seen && gap_cnt <= 3300 * tk |-> gap_cnt >= 2700 * tk)
      else $error("slot too short");
   det_retry_a:
   assert property ($fell(DET_SRC_EN) && det_cnt >= 3000 * tk && !PORT_ON && !$past(WR) && !$past(WR, 2)
      |-> PREBIAS_EN) else $error("no retry after timeout");
endmodule

bind podl_pse_port_power_sequencer podl_pse_chk #(.TICK_DIV(TICK_DIV)) podl_pse_chk_i (
   .CLK_SYS(CLK_SYS), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
   .IRQ(IRQ), .PREBIAS_CURRENT_OK(PREBIAS_CURRENT_OK), .SIGNATURE_WINDOW_OK(SIGNATURE_WINDOW_OK),
   .PREBIAS_EN(PREBIAS_EN), .DET_SRC_EN(DET_SRC_EN), .PORT_ON(PORT_ON), .LINE_I(LINE_I),
   .LINE_O(LINE_O), .LINE_OE(LINE_OE));

// ### sim/pd_class_model.sv
// ==========================================
// Powered-device classification controller
module pd_class_model #(
   parameter int TICK = 1
) (
   input wire logic clk, // Clock
   input wire logic line, // Line level
   input wire logic present, // Answer a reset pulse
   input wire logic [23:0] reply, // Check byte, byte1, byte0
   output logic pull, // Pull line low
   output logic [15:0] cmd // Command bits seen
);
   timeunit 1ns;
   timeprecision 1ps;
   int n;
   int low;
   initial begin
      pull = 1'b0;
      cmd = 16'h0;
      forever begin
         n = 0;
         while (n < 5000 * TICK) begin
            @(posedge clk);
            n = line ? 0 : n + 1;
         end
         while (!line) @(posedge clk);
         if (present) begin
            repeat (1000 * TICK) @(posedge clk);
            pull <= 1'b1;
            repeat (4000 * TICK) @(posedge clk);
            pull <= 1'b0;
            for (int i = 0; i < 40; i++) begin
               @(negedge line);
               if (i < 16) begin
                  low = 0;
                  while (!line) begin
                     @(posedge clk);
                     low++;
                  end
                  cmd[i] = low < 1250 * TICK;
               end else begin
                  pull <= !reply[i - 16];
                  repeat (2000 * TICK) @(posedge clk);
                  pull <= 1'b0;
               end
            end
         end
      end
   end
endmodule

// ### sim/podl_pse_port_power_sequencer_tb.sv
`include "podl_pse_consts.svh"

module podl_pse_port_power_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK_SYS = 1'b0;
   logic RST_N = 1'b0;
   logic [7:0] ADDR = 8'h00;
   logic [31:0] WDATA = 32'h0;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic PREBIAS_CURRENT_OK = 1'b0;
   logic SIGNATURE_WINDOW_OK = 1'b0;
   logic [31:0] RDATA;
   logic IRQ, PREBIAS_EN, DET_SRC_EN, PORT_ON, LINE_I, LINE_O, LINE_OE, pull;
   logic present = 1'b0;
   logic [23:0] reply = 24'h0;
   logic [15:0] cmd;
   int n_errors = 0;
   int n_tests = 0;
   int t;
   always #12.5 CLK_SYS = !CLK_SYS;
   assign LINE_I = !(LINE_OE || pull);
   podl_pse_port_power_sequencer #(.TICK_DIV(16'h0001)) podl_pse_port_power_sequencer_i (
      .CLK_SYS(CLK_SYS), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .IRQ(IRQ), .PREBIAS_CURRENT_OK(PREBIAS_CURRENT_OK), .SIGNATURE_WINDOW_OK(SIGNATURE_WINDOW_OK),
      .PREBIAS_EN(PREBIAS_EN), .DET_SRC_EN(DET_SRC_EN), .PORT_ON(PORT_ON), .LINE_I(LINE_I),
      .LINE_O(LINE_O), .LINE_OE(LINE_OE));
   pd_class_model #(.TICK(1)) pd_class_model_i (.clk(CLK_SYS), .line(LINE_I), .present(present),
      .reply(reply), .pull(pull), .cmd(cmd));
   // ==========================================
   // Shared tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK_SYS);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK_SYS);
      WR <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge CLK_SYS);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK_SYS);
      RD <= 1'b0;
      #1 chk(RDATA, exp);
      @(posedge CLK_SYS);
      #1 chk(RDATA, 32'h0);
   endtask
   function automatic logic pin(input int s);
      case (s)
         0: return PREBIAS_EN;
         1: return DET_SRC_EN;
         2: return PORT_ON;
         default: return LINE_OE;
      endcase
   endfunction
   // Counts edges in t until the pin reaches v
   task automatic wait_pin(input int s, input logic v, input int lim);
      t = 0;
      while (pin(s) !== v) begin
         if (t >= lim) begin
            chk(32'(s), 32'hff);
            report_and_stop();
         end
         @(posedge CLK_SYS);
         #1;
         t++;
      end
   endtask
   task automatic stay(input int s, input logic v, input int n);
      logic bad;
      bad = 1'b0;
      repeat (n) begin
         @(posedge CLK_SYS);
         #1;
         if (pin(s) !== v) bad = 1'b1;
      end
      chk(32'(bad), 32'h0);
   endtask
   function automatic logic [7:0] crc8(input logic [15:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 16; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
      return c;
   endfunction
   // ==========================================
   // Scenarios
   task automatic sc_regs();
      #1 chk(32'({PREBIAS_EN, DET_SRC_EN, PORT_ON, LINE_OE, IRQ}), 32'h0);
      rd_chk(`ADDR_CTRL, 32'h00000ffc);
      rd_chk(`ADDR_IRQ_MASK, 32'h0);
      rd_chk(8'h10, 32'h0);
      wr(`ADDR_STATUS, 32'hffffffff);
      rd_chk(`ADDR_STATUS, 32'h0);
   endtask
   task automatic sc_prebias(input logic [31:0] ctrl);
      wr(`ADDR_CTRL, ctrl);
      wait_pin(0, 1'b1, 4);
      @(posedge CLK_SYS);
      PREBIAS_CURRENT_OK <= 1'b1;
      repeat (60) @(posedge CLK_SYS);
      PREBIAS_CURRENT_OK <= 1'b0;
      stay(1, 1'b0, 150);
      @(posedge CLK_SYS);
      PREBIAS_CURRENT_OK <= 1'b1;
      wait_pin(1, 1'b1, 120);
      chk(32'({PREBIAS_EN, t >= 100 && t <= 106}), 32'h1);
      PREBIAS_CURRENT_OK <= 1'b0;
   endtask
   task automatic sc_timeout();
      sc_prebias(32'h00000ffd);
      SIGNATURE_WINDOW_OK <= 1'b1;
      repeat (60) @(posedge CLK_SYS);
      SIGNATURE_WINDOW_OK <= 1'b0;
      wait_pin(1, 1'b0, 3200);
      chk(32'({PREBIAS_EN, t >= 3045 && t <= 3056}), 32'h3);
      rd_chk(`ADDR_IRQ_STATUS, 32'h10);
      chk(32'(IRQ), 32'h0);
      wr(`ADDR_IRQ_MASK, 32'h1f);
      #1 chk(32'(IRQ), 32'h1);
      wr(`ADDR_IRQ_STATUS, 32'h10);
      #1 chk(32'(IRQ), 32'h0);
   endtask
   task automatic sc_direct();
      sc_prebias(32'h00000ffd);
      SIGNATURE_WINDOW_OK <= 1'b1;
      wait_pin(2, 1'b1, 1100);
      chk(32'({t >= 1000 && t <= 1006, DET_SRC_EN, LINE_OE}), 32'h4);
      rd_chk(`ADDR_IRQ_STATUS, 32'h01);
      wr(`ADDR_CTRL, 32'h00000ffc);
      SIGNATURE_WINDOW_OK <= 1'b0;
      repeat (2) @(posedge CLK_SYS);
      #1 chk(32'({PREBIAS_EN, DET_SRC_EN, PORT_ON, LINE_OE}), 32'h0);
      wr(`ADDR_IRQ_STATUS, 32'h1f);
   endtask
   task automatic sc_nopres();
      present <= 1'b0;
      sc_prebias(32'h00000fff);
      SIGNATURE_WINDOW_OK <= 1'b1;
      wait_pin(3, 1'b1, 1100);
      chk(32'(LINE_O), 32'h0);
      wait_pin(3, 1'b0, 10100);
      chk(32'(t >= 9999 && t <= 10001), 32'h1);
      stay(3, 1'b0, 1600);
      wait_pin(1, 1'b0, 400);
      chk(32'({PREBIAS_EN, PORT_ON}), 32'h0);
      rd_chk(`ADDR_CTRL, 32'h00000ffe);
      rd_chk(`ADDR_IRQ_STATUS, 32'h02);
      wr(`ADDR_IRQ_STATUS, 32'h1f);
      SIGNATURE_WINDOW_OK <= 1'b0;
   endtask
   task automatic sc_class();
      present <= 1'b1;
      reply <= {crc8(16'h1235), 16'h1235};
      sc_prebias(32'h00000fff);
      SIGNATURE_WINDOW_OK <= 1'b1;
      wait_pin(2, 1'b1, 145000);
      chk(32'(cmd), 32'h0000aacc);
      rd_chk(`ADDR_STATUS, 32'h00123518);
      rd_chk(`ADDR_IRQ_STATUS, 32'h01);
   endtask
   initial begin
      repeat (8) @(posedge CLK_SYS);
      RST_N <= 1'b1;
      sc_regs();
      sc_timeout();
      sc_direct();
      sc_nopres();
      sc_class();
      report_and_stop();
   end
endmodule
